/* File: verilog/socw_pkg.sv */
package socw_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_SCRATCH = 8'h17;
  localparam logic [7:0] IDX_FAULT_EN = 8'h18;
  localparam logic [7:0] IDX_NIB_CFG = 8'h19;
  localparam logic [7:0] IDX_MASK = 8'h1a;
  localparam logic [7:0] IDX_COMMON = 8'h1e;
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam logic [7:0] IDX_TURNS = 8'h42;
  localparam logic [7:0] IDX_DUTY = 8'h43;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int W24 = 24;
  localparam int W26 = 26;

  // Common word fields
  localparam int COM_LOCK_LSB = 20;
  localparam int UNLOCK_FREE_WRITE_ENABLE_BIT = 17;
  localparam int LOCK_WRITE_OVERRIDE_BIT = 16;

  // Fault enable word
  localparam int FE_TOV_BIT = 12;
  localparam int FE_OFS_LSB = 13;
  localparam int OFS_W = 11;

  // Nibble config fields
  localparam int NC_FA = 0;
  localparam int NC_XA = 1;
  localparam int NC_ZS = 2;
  localparam int NC_NS = 3;
  localparam int NC_SCN_LSB = 4;
  localparam int NC_CIS = 7;
  localparam int NC_DATA_LSB = 8;
  localparam int NC_MODE_LSB = 12;
  localparam int NC_SM = 15;
  localparam int NC_TICK_LSB = 16;
  localparam int NC_SS = 23;
  localparam int NC_HIGHEST_SLOT_ID_LSB = 24;
  localparam logic [6:0] TICK_MIN = 7'h02;

  // Control word fields
  localparam int CT_PEN = 0;
  localparam int CT_PEO = 1;
  localparam int CT_PES = 2;
  localparam int CT_DM = 3;
  localparam int CT_SPO = 4;
  localparam int CT_CUL = 5;

  // Duty codes in units of 1/160 of the period: 5% steps of 5.625%
  localparam logic [7:0] DUTY_BASE = 8'h08;
  localparam logic [7:0] DUTY_STEP = 8'h09;

  typedef enum logic [2:0] {
    SOCW_OFF, SOCW_STREAM, SOCW_STREAM_PAUSE, SOCW_TRIG_LATE,
    SOCW_TRIG_EDGE, SOCW_ASYNC, SOCW_SHARED, SOCW_SHARED_LONG
  } socw_mode_t;
endpackage

/* File: verilog/socw_regs.sv */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Scratch word writable while memory locked
// - Scratch writable without unlock when permitted
// - Watchdog 5%, uncorrectable 10.625% fault duty
// - Selftest 16.25%, PLL unlock 21.875% duty
// - Zero-cross 27.5%, averaging 33.125% duty
// - Undervoltage 38.75%, field low 44.375% duty
// - Soft memory 50%, saturation 55.625% duty
// - Field high 61.25%, temperature 66.875% duty
// - Turns overflow 72.5% duty when enabled
// - Offset added to zero-cross angle for turns
// - Pulse addressing versus broadcast select bits
// - Skip sample-hold; hold in slot zero
// - Status nibble filled per 3-bit layout
// - CRC covers status nibble when set
// - Data nibble content per 4-bit mode
// - Output mode selects nibble behaviour
// - PWM enable wins, nibble output off
// - Manchester active when both outputs off and CT_DM, CT_SPO clear
// - Slot marking delay and slot sync
// - Tick length in clocks, minimum two
// - Slot counter wraps after highest ID
// - Mask bits hide matching errors
// - Fault select halves carrier or tristates
module socw_regs
  import socw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [12:0] fault_in,
  input  wire logic [7:0]  err_in,
  input  wire logic [10:0] zero_cross_angle,
  input  wire logic        soft_flag,
  input  wire logic        hard_flag,
  input  wire logic        msg_sync,
  input  wire logic        msg_data,
  input  wire logic [1:0]  sensor_id,
  input  wire logic        slot_advance,
  output logic      [7:0]  err_visible,
  output logic      [10:0] turns_angle,
  output logic      [3:0]  status_nibble,
  output logic             crc_covers_status,
  output logic      [3:0]  data_layout,
  output logic      [2:0]  nibble_output_mode,
  output logic             nibble_active,
  output logic             pwm_active,
  output logic             pwm_half_carrier,
  output logic             pwm_tristate,
  output logic      [7:0]  pwm_fault_duty,
  output logic             manchester_active,
  output logic             sample_pulse_addressed,
  output logic             aux_pulse_addressed,
  output logic             sample_hold_en,
  output logic             hold_in_slot_zero,
  output logic             slot_marking_en,
  output logic             slot_sync_en,
  output logic      [6:0]  tick_length,
  output logic      [1:0]  slot_count
);
  logic [W24-1:0] scratch_reg, fault_en_reg, mask_reg, common_reg;
  logic [W26-1:0] nib_cfg_reg;
  logic [5:0]     ctrl_reg;
  logic [1:0]     slot_reg;
  logic [7:0]     duty_next;
  logic           fault_any;
  logic [7:0]     idx;
  logic           wr;
  logic           mapped;
  logic [2:0]     scn;
  logic           sf_or;

  function automatic logic [7:0] duty_of(input logic [3:0] n);
    duty_of = DUTY_BASE + 8'(n) * DUTY_STEP;
  endfunction

  assign idx = paddr[9:2];
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
    (idx == IDX_SCRATCH || idx == IDX_FAULT_EN || idx == IDX_NIB_CFG ||
     idx == IDX_MASK || idx == IDX_COMMON || idx == IDX_CTRL ||
     idx == IDX_STATUS || idx == IDX_TURNS || idx == IDX_DUTY);
  assign pslverr = psel && penable && !mapped;

  // Scratch ignores the lock; unlock is needed unless both permits set
  logic scratch_ok;
  assign scratch_ok = ctrl_reg[CT_CUL] ||
    (common_reg[UNLOCK_FREE_WRITE_ENABLE_BIT] && common_reg[LOCK_WRITE_OVERRIDE_BIT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_reg <= RST_WORD[W24-1:0];
    end else if (wr && mapped && idx == IDX_SCRATCH && scratch_ok) begin
      scratch_reg <= pwdata[W24-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_en_reg <= RST_WORD[W24-1:0];
      nib_cfg_reg  <= RST_WORD[W26-1:0];
      mask_reg     <= RST_WORD[W24-1:0];
      common_reg   <= RST_WORD[W24-1:0];
      ctrl_reg     <= RST_WORD[5:0];
    end else if (wr && mapped) begin
      // Lock applies to the fault enable, nibble config and mask words only
      if (common_reg[COM_LOCK_LSB +: 4] == 4'h0) begin
        if (idx == IDX_FAULT_EN) fault_en_reg <= pwdata[W24-1:0];
        if (idx == IDX_NIB_CFG) nib_cfg_reg <= pwdata[W26-1:0];
        if (idx == IDX_MASK) mask_reg <= pwdata[W24-1:0];
      end
      if (idx == IDX_COMMON) common_reg <= pwdata[W24-1:0];
      if (idx == IDX_CTRL) ctrl_reg <= pwdata[5:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && mapped) begin
      unique case (idx)
        IDX_SCRATCH:  prdata = {8'h00, scratch_reg};
        IDX_FAULT_EN: prdata = {8'h00, fault_en_reg};
        IDX_NIB_CFG:  prdata = {6'h00, nib_cfg_reg};
        IDX_MASK:     prdata = {8'h00, mask_reg};
        IDX_COMMON:   prdata = {8'h00, common_reg};
        IDX_CTRL:     prdata = {26'h000_0000, ctrl_reg};
        IDX_STATUS:   prdata = {20'h0_0000, pwm_half_carrier,
                                pwm_tristate, err_visible, slot_reg};
        IDX_TURNS:    prdata = {21'h00_0000, turns_angle};
        IDX_DUTY:     prdata = {24'h00_0000, pwm_fault_duty};
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  assign err_visible = err_in & ~mask_reg[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) turns_angle <= 11'h000;
    else turns_angle <= 11'(zero_cross_angle +
      fault_en_reg[FE_OFS_LSB +: OFS_W]);
  end

  // Lowest enabled fault index has highest priority
  always_comb begin
    duty_next = 8'h00;
    fault_any = 1'b0;
    for (int i = FE_TOV_BIT; i >= 0; i--) begin
      if (fault_in[i] && fault_en_reg[i]) begin
        duty_next = duty_of(4'(i));
        fault_any = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pwm_fault_duty <= 8'h00;
    else pwm_fault_duty <= duty_next;
  end

  // Tristate latches until reset or the output enable is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_half_carrier <= 1'b0;
      pwm_tristate <= 1'b0;
    end else begin
      pwm_half_carrier <= ctrl_reg[CT_PEO] && ctrl_reg[CT_PES] &&
        fault_any;
      if (!ctrl_reg[CT_PEO]) pwm_tristate <= 1'b0;
      else if (!ctrl_reg[CT_PES] && fault_any) pwm_tristate <= 1'b1;
    end
  end

  assign nibble_output_mode = nib_cfg_reg[NC_MODE_LSB +: 3];
  assign pwm_active = ctrl_reg[CT_PEN];
  assign nibble_active = !ctrl_reg[CT_PEN] &&
    nibble_output_mode != SOCW_OFF;
  assign manchester_active = !ctrl_reg[CT_PEN] &&
    nibble_output_mode == SOCW_OFF &&
    !ctrl_reg[CT_DM] && !ctrl_reg[CT_SPO];

  assign sample_pulse_addressed = nib_cfg_reg[NC_FA];
  assign aux_pulse_addressed = nib_cfg_reg[NC_XA];
  assign sample_hold_en = !nib_cfg_reg[NC_NS];
  assign hold_in_slot_zero = nib_cfg_reg[NC_ZS];
  assign crc_covers_status = nib_cfg_reg[NC_CIS];
  assign data_layout = nib_cfg_reg[NC_DATA_LSB +: 4];

  // Slot marking only meaningful in shared-bus modes
  logic shared;
  assign shared = nibble_output_mode == SOCW_SHARED ||
    nibble_output_mode == SOCW_SHARED_LONG;
  assign slot_marking_en = shared && nib_cfg_reg[NC_SM];
  assign slot_sync_en = slot_marking_en && nib_cfg_reg[NC_SS];

  assign tick_length = (nib_cfg_reg[NC_TICK_LSB +: 7] < TICK_MIN) ?
    TICK_MIN : nib_cfg_reg[NC_TICK_LSB +: 7];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) slot_reg <= 2'b00;
    else if (shared && slot_advance) begin
      if (slot_reg >= nib_cfg_reg[NC_HIGHEST_SLOT_ID_LSB +: 2]) slot_reg <= 2'b00;
      else slot_reg <= slot_reg + 2'b01;
    end
  end
  assign slot_count = slot_reg;

  assign scn = nib_cfg_reg[NC_SCN_LSB +: 3];
  assign sf_or = soft_flag | hard_flag;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_nibble <= 4'h0;
    else begin
      unique case (scn)
        3'd0: status_nibble <= {2'b00, soft_flag, hard_flag};
        3'd1: status_nibble <= {msg_sync, msg_data, soft_flag, hard_flag};
        3'd2: status_nibble <= {sensor_id, soft_flag, hard_flag};
        3'd3: status_nibble <= {3'b000, sf_or};
        3'd4: status_nibble <= {2'b00, sensor_id};
        3'd5: status_nibble <= {msg_sync, msg_data, sensor_id};
        3'd6: status_nibble <= {soft_flag, hard_flag, sensor_id};
        3'd7: status_nibble <= {msg_sync, msg_data, 1'b0, sf_or};
      endcase
    end
  end

  // Write strobe aimed at the scratch word
  sequence s_scratch_wr;
    wr && mapped && idx == IDX_SCRATCH;
  endsequence

  chk_tick_min_floor: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick_length >= TICK_MIN)
    else $error("tick below floor");

  chk_tick_passes: assert property (
    @(posedge pclk) disable iff (!presetn)
    nib_cfg_reg[NC_TICK_LSB +: 7] >= TICK_MIN
    |-> tick_length == nib_cfg_reg[NC_TICK_LSB +: 7])
    else $error("tick not passed through");

  chk_pwm_wins_nibble: assert property (
    @(posedge pclk) disable iff (!presetn)
    pwm_active |-> !nibble_active && !manchester_active)
    else $error("pwm not exclusive");

  chk_mask_hides_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (err_visible & mask_reg[7:0]) == 8'h00)
    else $error("masked error visible");

  // Slot counter only moves on an advance in shared-bus modes
  chk_slot_wraps_max: assert property (
    @(posedge pclk) disable iff (!presetn)
    shared && slot_advance && slot_reg == nib_cfg_reg[NC_HIGHEST_SLOT_ID_LSB +: 2]
    |=> slot_reg == 2'b00)
    else $error("slot no wrap");

  chk_slot_step_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    shared && slot_advance && slot_reg < nib_cfg_reg[NC_HIGHEST_SLOT_ID_LSB +: 2]
    |=> slot_reg == $past(slot_reg) + 2'b01)
    else $error("slot step wrong");

  chk_slot_hold_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(shared && slot_advance) |=> $stable(slot_reg))
    else $error("slot moved while idle");

  chk_sync_needs_mark: assert property (
    @(posedge pclk) disable iff (!presetn)
    slot_sync_en |-> slot_marking_en)
    else $error("slot sync without marking");

  chk_skip_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    nib_cfg_reg[NC_NS] |-> !sample_hold_en)
    else $error("sample hold not skipped");

  chk_scn_or_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    scn == 3'd3 |=> status_nibble == {3'b000, $past(sf_or)})
    else $error("status nibble or mode wrong");

  chk_turns_offset_add: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 turns_angle == 11'($past(zero_cross_angle) +
    $past(fault_en_reg[FE_OFS_LSB +: OFS_W])))
    else $error("turns offset wrong");

  chk_scratch_write_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_scratch_wr ##0 scratch_ok
    |=> scratch_reg == $past(pwdata[W24-1:0]))
    else $error("scratch write lost");

  // The lock must never block the scratch word
  chk_scratch_lock_free: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_scratch_wr ##0 scratch_ok && common_reg[COM_LOCK_LSB +: 4] != 4'h0
    |=> scratch_reg == $past(pwdata[W24-1:0]))
    else $error("locked scratch write lost");

  chk_scratch_denied: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_scratch_wr ##0 !scratch_ok |=> $stable(scratch_reg))
    else $error("scratch written without permit");

  // One check per fault code; lower bits idle so that fault wins
  chk_wd_duty_five: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[0] && fault_en_reg[0] |=> pwm_fault_duty == DUTY_BASE)
    else $error("watchdog duty wrong");

  chk_eue_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[1:0] == 2'b10 && fault_en_reg[1] |=> pwm_fault_duty == 8'h11)
    else $error("uncorrectable duty wrong");

  chk_stf_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[2:0] == 3'h4 && fault_en_reg[2] |=> pwm_fault_duty == 8'h1a)
    else $error("selftest duty wrong");

  chk_pll_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[3:0] == 4'h8 && fault_en_reg[3] |=> pwm_fault_duty == 8'h23)
    else $error("pll duty wrong");

  chk_zie_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[4:0] == 5'h10 && fault_en_reg[4] |=> pwm_fault_duty == 8'h2c)
    else $error("zero cross duty wrong");

  chk_avg_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[5:0] == 6'h20 && fault_en_reg[5] |=> pwm_fault_duty == 8'h35)
    else $error("averaging duty wrong");

  chk_uv_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[6:0] == 7'h40 && fault_en_reg[6] |=> pwm_fault_duty == 8'h3e)
    else $error("undervoltage duty wrong");

  chk_low_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[7:0] == 8'h80 && fault_en_reg[7] |=> pwm_fault_duty == 8'h47)
    else $error("field low duty wrong");

  chk_soft_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[8:0] == 9'h100 && fault_en_reg[8] |=> pwm_fault_duty == 8'h50)
    else $error("soft error duty wrong");

  chk_sat_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[9:0] == 10'h200 && fault_en_reg[9]
    |=> pwm_fault_duty == 8'h59)
    else $error("saturation duty wrong");

  chk_high_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[10:0] == 11'h400 && fault_en_reg[10]
    |=> pwm_fault_duty == 8'h62)
    else $error("field high duty wrong");

  chk_temp_duty: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[11:0] == 12'h800 && fault_en_reg[11]
    |=> pwm_fault_duty == 8'h6b)
    else $error("temperature duty wrong");

  chk_tov_duty_last: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_in[12:0] == 13'h1000 && fault_en_reg[12]
    |=> pwm_fault_duty == 8'h74)
    else $error("turns duty wrong");

  // Fault response: half carrier, or a tristate that sticks
  chk_half_on_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[CT_PEO] && ctrl_reg[CT_PES] && fault_any
    |=> pwm_half_carrier)
    else $error("carrier not halved");

  chk_tri_on_fault: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[CT_PEO] && !ctrl_reg[CT_PES] && fault_any |=> pwm_tristate)
    else $error("pwm not tristated");

  chk_tri_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    pwm_tristate && ctrl_reg[CT_PEO] |=> pwm_tristate)
    else $error("tristate released early");

  chk_tri_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_reg[CT_PEO] |=> !pwm_tristate)
    else $error("tristate not released");

  chk_manch_when_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_reg[CT_PEN] && nibble_output_mode == SOCW_OFF && !ctrl_reg[CT_DM]
    && !ctrl_reg[CT_SPO] |-> manchester_active)
    else $error("manchester off");
endmodule

/* File: sim/socw_ecu_model.sv */
`timescale 1ns/1ns
module socw_ecu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pwm_tristate,
  input  wire logic       pwm_half_carrier,
  input  wire logic [7:0] pwm_fault_duty,
  output logic      [7:0] ecu_duty
);
  // Reader only; a floating line reads as all ones, never a stale code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecu_duty <= 8'hff;
    end else if (pwm_tristate || !pwm_half_carrier) begin
      ecu_duty <= 8'hff;
    end else begin
      ecu_duty <= pwm_fault_duty;
    end
  end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
  import socw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, v;
  logic [12:0] fault_in;
  logic [10:0] zero_cross_angle, turns_angle;
  logic [7:0]  err_in, err_visible, pwm_fault_duty, ecu_duty;
  logic [6:0]  tick_length;
  logic [3:0]  status_nibble, data_layout;
  logic [2:0]  nibble_output_mode;
  logic [1:0]  sensor_id, slot_count;
  logic        soft_flag, hard_flag, msg_sync, msg_data, slot_advance;
  logic        crc_covers_status, nibble_active, pwm_active, pwm_tristate;
  logic        pwm_half_carrier, manchester_active, sample_pulse_addressed;
  logic        aux_pulse_addressed, sample_hold_en, hold_in_slot_zero;
  logic        slot_marking_en, slot_sync_en;
  int          miscompares, checks;

  socw_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fault_in, .err_in,
    .zero_cross_angle, .soft_flag, .hard_flag, .msg_sync, .msg_data,
    .sensor_id, .slot_advance, .err_visible, .turns_angle, .status_nibble,
    .crc_covers_status, .data_layout, .nibble_output_mode, .nibble_active,
    .pwm_active, .pwm_half_carrier, .pwm_tristate, .pwm_fault_duty,
    .manchester_active, .sample_pulse_addressed, .aux_pulse_addressed,
    .sample_hold_en, .hold_in_slot_zero, .slot_marking_en, .slot_sync_en,
    .tick_length, .slot_count);
  socw_ecu_model u_ecu (.pclk, .presetn, .pwm_tristate, .pwm_half_carrier,
    .pwm_fault_duty, .ecu_duty);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask

  // Settle past the edge so registered outputs have landed
  task automatic cyc(int k);
    repeat (k) @(posedge pclk);
    #2;
  endtask

  task automatic apb(logic w, logic [7:0] idx, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end else begin
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  function automatic logic [3:0] scn(logic [2:0] m);
    case (m)
      3'd0: return {2'b00, soft_flag, hard_flag};
      3'd1: return {msg_sync, msg_data, soft_flag, hard_flag};
      3'd2: return {sensor_id, soft_flag, hard_flag};
      3'd3: return {3'b000, soft_flag | hard_flag};
      3'd4: return {2'b00, sensor_id};
      3'd5: return {msg_sync, msg_data, sensor_id};
      3'd6: return {soft_flag, hard_flag, sensor_id};
      default: return {msg_sync, msg_data, 1'b0, soft_flag | hard_flag};
    endcase
  endfunction

  initial begin
    {psel, penable, pwrite, paddr, pwdata, fault_in, err_in} = '0;
    {zero_cross_angle, sensor_id, slot_advance, presetn} = '0;
    {soft_flag, hard_flag, msg_sync, msg_data} = 4'b1010;
    sensor_id = 2'b10;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    chk("tick_rst", tick_length, 2);
    chk("manch_rst", manchester_active, 1);
    apb(1, IDX_COMMON, 32'h0010_0000);
    apb(1, IDX_SCRATCH, 32'h00ab_cdef);
    apb(0, IDX_SCRATCH, 0);
    chk("scr_denied", rv, 0);
    apb(1, IDX_COMMON, 32'h0013_0000);
    apb(1, IDX_SCRATCH, 32'h00ab_cdef);
    apb(1, IDX_MASK, 32'h0000_00ff);
    apb(0, IDX_SCRATCH, 0);
    chk("scr_locked", rv, 32'h00ab_cdef);
    apb(0, IDX_MASK, 0);
    chk("mask_locked", rv, 0);
    apb(0, 8'h80, 0);
    chk("unmapped", err, 1);
    apb(1, IDX_COMMON, 0);
    apb(1, IDX_CTRL, 32'h0000_0020);
    apb(1, IDX_SCRATCH, 32'h0012_3456);
    apb(0, IDX_SCRATCH, 0);
    chk("scr_unlocked", rv, 32'h0012_3456);
    $display("test access done");
    apb(1, IDX_MASK, 32'h0000_005a);
    err_in <= 8'hff;
    cyc(1);
    chk("err_visible", err_visible, 8'ha5);
    apb(1, IDX_FAULT_EN, {8'h00, 11'h005, 13'h1fff});
    zero_cross_angle <= 11'h7fe;
    apb(1, IDX_CTRL, 32'h0000_0007);
    cyc(2);
    chk("turns", turns_angle, 11'h003);
    chk("pwm_on", {pwm_active, nibble_active}, 2'b10);
    for (int i = 0; i < 13; i++) begin
      @(posedge pclk);
      fault_in <= 13'h0001 << i;
      cyc(2);
      chk("duty", pwm_fault_duty, 8 + 9 * i);
    end
    @(posedge pclk);
    fault_in <= 13'h0030;
    cyc(3);
    chk("half", pwm_half_carrier, 1);
    chk("ecu_duty", ecu_duty, 8'd44);
    apb(0, IDX_DUTY, 0);
    chk("duty_reg", rv, 44);
    apb(0, IDX_TURNS, 0);
    chk("turns_reg", rv, 3);
    apb(0, IDX_STATUS, 0);
    chk("status_reg", rv, 32'h0000_0a94);
    apb(1, IDX_CTRL, 32'h0000_0003);
    cyc(2);
    chk("tristate", pwm_tristate, 1);
    apb(1, IDX_CTRL, 32'h0000_0001);
    cyc(2);
    chk("release", pwm_tristate, 0);
    @(posedge pclk);
    fault_in <= '0;
    apb(1, IDX_CTRL, 0);
    $display("test faults done");
    for (int m = 0; m < 8; m++) begin
      v = {6'h00, 2'b10, 1'b1, 7'h01, 1'b1, 3'(m), 4'hc, 1'b1, 3'(m), 4'b0101};
      apb(1, IDX_NIB_CFG, v);
      cyc(2);
      chk("mode", nibble_output_mode, m);
      chk("nib_on", nibble_active, m != 0);
      chk("manch", manchester_active, m == 0);
      chk("status", status_nibble, scn(3'(m)));
      chk("tick_min", tick_length, 2);
      chk("layout", data_layout, 4'hc);
      chk("crc", crc_covers_status, 1);
      chk("pulses", {sample_pulse_addressed, aux_pulse_addressed}, 2);
      chk("hold", {sample_hold_en, hold_in_slot_zero}, 3);
      chk("slot_cfg", {slot_marking_en, slot_sync_en}, (m >= 6) ? 3 : 0);
    end
    apb(1, IDX_NIB_CFG, 32'h007f_0000);
    cyc(1);
    chk("tick_max", tick_length, 7'h7f);
    apb(1, IDX_CTRL, 32'h0000_0008);
    cyc(1);
    chk("manch_off", manchester_active, 0);
    apb(1, IDX_NIB_CFG, 32'h0200_6000);
    for (int k = 1; k < 5; k++) begin
      @(posedge pclk);
      slot_advance <= 1'b1;
      @(posedge pclk);
      slot_advance <= 1'b0;
      cyc(1);
      chk("slot", slot_count, k % 3);
    end
    $display("test nibble done");
    stop_test();
  end
endmodule
